// ---- hdl/iep_gate.sv ----
// per-source request gate: a request passes only where flag, enable and mask agree
module iep_gate #(
  parameter int W = 16
) (
  input  wire logic [W-1:0] flag,
  input  wire logic [W-1:0] en,
  input  wire logic [W-1:0] mask,
  output logic      [W-1:0] req
);

  assign req = flag & en & mask; // [RULE1] [RULE14]

endmodule

// ---- hdl/iep_pkg.sv ----
// constants, field positions and state type of the interrupt enable/priority registers
package iep_pkg;

  localparam int          AXI_ADDR_W = 8;
  localparam int          AXI_DATA_W = 32;
  localparam int          REG_W      = 16;
  localparam int          LEVEL_W    = 3;

  // byte offsets on the register bus
  localparam logic [7:0]  OFS_ENABLE_3   = 8'h00;
  localparam logic [7:0]  OFS_ENABLE_4   = 8'h04;
  localparam logic [7:0]  OFS_ENABLE_5   = 8'h08;
  localparam logic [7:0]  OFS_ENABLE_6   = 8'h0c;
  localparam logic [7:0]  OFS_PRIORITY_0 = 8'h10;
  localparam logic [7:0]  OFS_PENDING    = 8'h14;

  // enable register 3
  localparam int          CALENDAR_IRQ_EN_BIT    = 14;
  localparam int          EXT_INPUT4_IRQ_EN_BIT  = 6;
  localparam int          EXT_INPUT3_IRQ_EN_BIT  = 5;
  localparam int          I2C2_MASTER_IRQ_EN_BIT = 2;
  localparam int          I2C2_SLAVE_IRQ_EN_BIT  = 1;
  // enable register 4
  localparam int          CHARGE_TIME_IRQ_EN_BIT   = 13;
  localparam int          LOW_VOLTAGE_IRQ_EN_BIT   = 8;
  localparam int          CHECKSUM_GEN_IRQ_EN_BIT  = 3;
  localparam int          UART2_ERROR_IRQ_EN_BIT   = 2;
  localparam int          UART1_ERROR_IRQ_EN_BIT   = 1;
  // enable register 5
  localparam int          CAPTURE9_IRQ_EN_BIT       = 13;
  localparam int          COMPARE9_IRQ_EN_BIT       = 12;
  localparam int          SPI3_EVENT_IRQ_EN_BIT     = 11;
  localparam int          SPI3_FAULT_IRQ_EN_BIT     = 10;
  localparam int          UART4_TRANSMIT_IRQ_EN_BIT = 9;
  localparam int          UART4_RECEIVE_IRQ_EN_BIT  = 8;
  localparam int          UART4_ERROR_IRQ_EN_BIT    = 7;
  localparam int          USB_OTG_IRQ_EN_BIT        = 6;
  localparam int          I2C3_MASTER_IRQ_EN_BIT    = 5;
  localparam int          I2C3_SLAVE_IRQ_EN_BIT     = 4;
  localparam int          UART3_TRANSMIT_IRQ_EN_BIT = 3;
  localparam int          UART3_RECEIVE_IRQ_EN_BIT  = 2;
  localparam int          UART3_ERROR_IRQ_EN_BIT    = 1;
  // enable register 6
  localparam int          GRAPHICS_IRQ_EN_BIT = 4;

  // priority register 0, lowest bit of each 3-bit field
  localparam int          TIMER1_IRQ_LEVEL_LSB     = 12;
  localparam int          COMPARE1_IRQ_LEVEL_LSB   = 8;
  localparam int          CAPTURE1_IRQ_LEVEL_LSB   = 4;
  localparam int          EXT_INPUT0_IRQ_LEVEL_LSB = 0;

  // implemented bits of each register
  localparam logic [15:0] ENABLE_3_MASK   = 16'h4066;
  localparam logic [15:0] ENABLE_4_MASK   = 16'h210e;
  localparam logic [15:0] ENABLE_5_MASK   = 16'h3ffe;
  localparam logic [15:0] ENABLE_6_MASK   = 16'h0010;
  localparam logic [15:0] PRIORITY_0_MASK = 16'h7777;
  localparam logic [15:0] PENDING_MASK    = 16'h00ff;

  // values after reset
  localparam logic [15:0] ENABLE_RST     = 16'h0000;
  localparam logic [15:0] PRIORITY_0_RST = 16'h4444;

  localparam logic [2:0]  LEVEL_OFF = 3'h0;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic                  aw_got;
    logic [AXI_ADDR_W-1:0] aw_addr;
    logic                  w_got;
    logic [REG_W-1:0]      w_data;
    logic [1:0]            w_strb;
    logic                  bvalid;
    logic [1:0]            bresp;
    logic                  rvalid;
    logic [1:0]            rresp;
    logic [REG_W-1:0]      rdata;
    logic [REG_W-1:0]      en3;
    logic [REG_W-1:0]      en4;
    logic [REG_W-1:0]      en5;
    logic [REG_W-1:0]      en6;
    logic [REG_W-1:0]      prio0;
    logic [REG_W-1:0]      req3;
    logic [REG_W-1:0]      req4;
    logic [REG_W-1:0]      req5;
    logic [REG_W-1:0]      req6;
    logic [3:0]            req_prio;
  } iep_state_t;

endpackage

// ---- hdl/iep_regs.sv ----
// interrupt enable registers 3..6 and priority register 0 behind an axi4-lite slave
//
// Summary of operation
// RULE1 - A source's request passes when its enable bit is one and is blocked when it is zero.
// RULE2 - Unimplemented bits of the enable and priority registers read zero and ignore writes.
// RULE3 - Power-on reset clears every implemented enable bit.
// RULE4 - Each 3-bit priority field resets to binary 100, level four.
// RULE5 - Priority code 111 gives the source level seven, the highest.
// RULE6 - Codes between map straight to levels, with 001 being level one, the lowest.
// RULE7 - Priority code 000 disables the source whatever its enable bit holds.
// RULE8 - Software enabling an external input must also route it to a remappable pin.
// RULE9 - Enable register 3 has calendar at 14, ext input 4 at 6, ext 3 at 5, i2c2 at 2 and 1.
// RULE10 - Enable register 4 has charge time 13, low voltage 8, checksum 3, uart2/1 error 2 and 1.
// RULE11 - Enable register 5 holds thirteen enables from capture 9 at bit 13 down to bit 1.
// RULE12 - Enable register 6 implements only the graphics enable at bit 4.
// RULE13 - Priority register 0 has timer1 at 14-12, compare1 10-8, capture1 6-4, ext0 2-0.
// RULE14 - A request reaches arbitration only with flag set, enable one and level nonzero.
//
// Chosen here: register access over AXI4-Lite and the register offsets.
module iep_regs
  import iep_pkg::*;
(
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]            s_axi_awprot,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [AXI_DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]            s_axi_arprot,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [AXI_DATA_W-1:0]      s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  input  wire logic [REG_W-1:0]      src_flag_3,
  input  wire logic [REG_W-1:0]      src_flag_4,
  input  wire logic [REG_W-1:0]      src_flag_5,
  input  wire logic [REG_W-1:0]      src_flag_6,
  input  wire logic                  timer1_pending,
  input  wire logic                  compare1_pending,
  input  wire logic                  capture1_pending,
  input  wire logic                  ext_input0_pending,
  output logic [REG_W-1:0]           irq_req_3,
  output logic [REG_W-1:0]           irq_req_4,
  output logic [REG_W-1:0]           irq_req_5,
  output logic [REG_W-1:0]           irq_req_6,
  output logic                       timer1_req,
  output logic                       compare1_req,
  output logic                       capture1_req,
  output logic                       ext_input0_req,
  output logic [LEVEL_W-1:0]         timer1_irq_level,
  output logic [LEVEL_W-1:0]         compare1_irq_level,
  output logic [LEVEL_W-1:0]         capture1_irq_level,
  output logic [LEVEL_W-1:0]         ext_input0_irq_level
);

  iep_state_t            st_r;
  iep_state_t            st_nxt;

  logic                  aw_hs;
  logic                  w_hs;
  logic                  ar_hs;
  logic                  aw_now;
  logic                  w_now;
  logic                  do_write;
  logic [AXI_ADDR_W-1:0] wr_addr;
  logic [REG_W-1:0]      wr_data;
  logic [1:0]            wr_strb;

  logic [REG_W-1:0]      gate_3;
  logic [REG_W-1:0]      gate_4;
  logic [REG_W-1:0]      gate_5;
  logic [REG_W-1:0]      gate_6;
  logic [3:0]            gate_prio;
  logic [3:0]            prio_flag;
  logic [3:0]            prio_live;
  logic [3:0]            prio_mask;

  // byte merge of a write, then only the implemented bits survive
  function automatic logic [REG_W-1:0] merge(
    input logic [REG_W-1:0] old,
    input logic [REG_W-1:0] data,
    input logic [1:0]       strb,
    input logic [REG_W-1:0] mask
  );
    logic [REG_W-1:0] bytes;
    bytes = {{8{strb[1]}}, {8{strb[0]}}};
    merge = ((data & bytes) | (old & ~bytes)) & mask; // [RULE2]
  endfunction

  // field of priority register 0 by its lowest bit
  function automatic logic [LEVEL_W-1:0] field(
    input logic [REG_W-1:0] prio,
    input int               lsb
  );
    field = prio[lsb +: LEVEL_W];
  endfunction

  // ------------------------------------------------------------------
  // bus handshakes
  // ------------------------------------------------------------------
  // one write at a time: channels close while a response is waiting
  assign s_axi_awready = !st_r.aw_got && !st_r.bvalid;
  assign s_axi_wready  = !st_r.w_got && !st_r.bvalid;
  assign s_axi_arready = !st_r.rvalid;

  assign aw_hs = s_axi_awvalid && s_axi_awready;
  assign w_hs  = s_axi_wvalid && s_axi_wready;
  assign ar_hs = s_axi_arvalid && s_axi_arready;

  // address and data may arrive together or in either order
  assign aw_now   = st_r.aw_got || aw_hs;
  assign w_now    = st_r.w_got || w_hs;
  assign do_write = aw_now && w_now && !st_r.bvalid;

  assign wr_addr = st_r.aw_got ? st_r.aw_addr : s_axi_awaddr;
  assign wr_data = st_r.w_got ? st_r.w_data : s_axi_wdata[REG_W-1:0];
  assign wr_strb = st_r.w_got ? st_r.w_strb : s_axi_wstrb[1:0];

  assign s_axi_bvalid = st_r.bvalid;
  assign s_axi_bresp  = st_r.bresp;
  assign s_axi_rvalid = st_r.rvalid;
  assign s_axi_rresp  = st_r.rresp;
  // upper half of every word reads zero
  assign s_axi_rdata  = {{(AXI_DATA_W-REG_W){1'b0}}, st_r.rdata};

  // ------------------------------------------------------------------
  // request gating
  // ------------------------------------------------------------------
  iep_gate #(
    .W (REG_W)
  ) u_gate_3 (
    .flag (src_flag_3),
    .en   (st_r.en3),
    .mask (ENABLE_3_MASK),
    .req  (gate_3)
  );

  iep_gate #(
    .W (REG_W)
  ) u_gate_4 (
    .flag (src_flag_4),
    .en   (st_r.en4),
    .mask (ENABLE_4_MASK),
    .req  (gate_4)
  );

  iep_gate #(
    .W (REG_W)
  ) u_gate_5 (
    .flag (src_flag_5),
    .en   (st_r.en5),
    .mask (ENABLE_5_MASK),
    .req  (gate_5)
  );

  iep_gate #(
    .W (REG_W)
  ) u_gate_6 (
    .flag (src_flag_6),
    .en   (st_r.en6),
    .mask (ENABLE_6_MASK),
    .req  (gate_6)
  );

  // the pending inputs already carry flag and enable from the other enable registers
  assign prio_flag = {timer1_pending, compare1_pending, capture1_pending, ext_input0_pending};

  // level 000 switches the source off; 001..111 stay live as levels one to seven
  assign prio_live[3] = field(st_r.prio0, TIMER1_IRQ_LEVEL_LSB) != LEVEL_OFF;     // [RULE7]
  assign prio_live[2] = field(st_r.prio0, COMPARE1_IRQ_LEVEL_LSB) != LEVEL_OFF;   // [RULE7]
  assign prio_live[1] = field(st_r.prio0, CAPTURE1_IRQ_LEVEL_LSB) != LEVEL_OFF;   // [RULE7]
  assign prio_live[0] = field(st_r.prio0, EXT_INPUT0_IRQ_LEVEL_LSB) != LEVEL_OFF; // [RULE7]
  assign prio_mask    = 4'hf;

  iep_gate #(
    .W (4)
  ) u_gate_prio (
    .flag (prio_flag),
    .en   (prio_live),
    .mask (prio_mask),
    .req  (gate_prio)
  );

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;

    if (aw_hs) begin
      st_nxt.aw_got  = 1'b1;
      st_nxt.aw_addr = s_axi_awaddr;
    end
    if (w_hs) begin
      st_nxt.w_got  = 1'b1;
      st_nxt.w_data = s_axi_wdata[REG_W-1:0];
      st_nxt.w_strb = s_axi_wstrb[1:0];
    end
    if (st_r.bvalid && s_axi_bready) begin
      st_nxt.bvalid = 1'b0;
    end

    if (do_write) begin
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got  = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp  = RESP_OKAY;
      // byte lane bits [1:0] are ignored: any address within a word selects it
      case ({wr_addr[AXI_ADDR_W-1:2], 2'b00})
        OFS_ENABLE_3: begin
          st_nxt.en3 = merge(st_r.en3, wr_data, wr_strb, ENABLE_3_MASK); // [RULE1] [RULE9]
        end
        OFS_ENABLE_4: begin
          st_nxt.en4 = merge(st_r.en4, wr_data, wr_strb, ENABLE_4_MASK); // [RULE1] [RULE10]
        end
        OFS_ENABLE_5: begin
          st_nxt.en5 = merge(st_r.en5, wr_data, wr_strb, ENABLE_5_MASK); // [RULE1] [RULE11]
        end
        OFS_ENABLE_6: begin
          st_nxt.en6 = merge(st_r.en6, wr_data, wr_strb, ENABLE_6_MASK); // [RULE1] [RULE12]
        end
        OFS_PRIORITY_0: begin
          // each field is stored as written: code n is level n
          st_nxt.prio0 = merge(st_r.prio0, wr_data, wr_strb, PRIORITY_0_MASK); // [RULE13] [RULE5] [RULE6]
        end
        OFS_PENDING: begin
          // read-only view of the gated requests; a write is accepted and dropped
          st_nxt.bresp = RESP_OKAY;
        end
        default: begin
          st_nxt.bresp = RESP_SLVERR;
        end
      endcase
    end

    if (st_r.rvalid && s_axi_rready) begin
      st_nxt.rvalid = 1'b0;
    end

    if (ar_hs) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp  = RESP_OKAY;
      case ({s_axi_araddr[AXI_ADDR_W-1:2], 2'b00})
        OFS_ENABLE_3: begin
          st_nxt.rdata = st_r.en3 & ENABLE_3_MASK; // [RULE2]
        end
        OFS_ENABLE_4: begin
          st_nxt.rdata = st_r.en4 & ENABLE_4_MASK; // [RULE2]
        end
        OFS_ENABLE_5: begin
          st_nxt.rdata = st_r.en5 & ENABLE_5_MASK; // [RULE2]
        end
        OFS_ENABLE_6: begin
          st_nxt.rdata = st_r.en6 & ENABLE_6_MASK; // [RULE2]
        end
        OFS_PRIORITY_0: begin
          st_nxt.rdata = st_r.prio0 & PRIORITY_0_MASK; // [RULE2]
        end
        OFS_PENDING: begin
          st_nxt.rdata = {8'h00,
                          |st_r.req6, |st_r.req5, |st_r.req4, |st_r.req3,
                          st_r.req_prio} & PENDING_MASK;
        end
        default: begin
          st_nxt.rdata = 16'h0000;
          st_nxt.rresp = RESP_SLVERR;
        end
      endcase
    end

    // requests are registered so the outputs come from flip-flops (one cycle behind flags)
    st_nxt.req3     = gate_3;    // [RULE1]
    st_nxt.req4     = gate_4;    // [RULE1]
    st_nxt.req5     = gate_5;    // [RULE1]
    st_nxt.req6     = gate_6;    // [RULE1]
    st_nxt.req_prio = gate_prio; // [RULE14]
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r       <= '0;
      st_r.en3   <= ENABLE_RST;     // [RULE3]
      st_r.en4   <= ENABLE_RST;     // [RULE3]
      st_r.en5   <= ENABLE_RST;     // [RULE3]
      st_r.en6   <= ENABLE_RST;     // [RULE3]
      st_r.prio0 <= PRIORITY_0_RST; // [RULE4]
    end else begin
      st_r <= st_nxt;
    end
  end

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  assign irq_req_3      = st_r.req3;
  assign irq_req_4      = st_r.req4;
  assign irq_req_5      = st_r.req5;
  assign irq_req_6      = st_r.req6;
  assign timer1_req     = st_r.req_prio[3];
  assign compare1_req   = st_r.req_prio[2];
  assign capture1_req   = st_r.req_prio[1];
  assign ext_input0_req = st_r.req_prio[0];

  // the arbiter compares these directly: 7 wins, 1 loses to all others
  assign timer1_irq_level     = field(st_r.prio0, TIMER1_IRQ_LEVEL_LSB);     // [RULE5] [RULE6]
  assign compare1_irq_level   = field(st_r.prio0, COMPARE1_IRQ_LEVEL_LSB);   // [RULE5] [RULE6]
  assign capture1_irq_level   = field(st_r.prio0, CAPTURE1_IRQ_LEVEL_LSB);   // [RULE5] [RULE6]
  assign ext_input0_irq_level = field(st_r.prio0, EXT_INPUT0_IRQ_LEVEL_LSB); // [RULE5] [RULE6]

endmodule

// ---- testbench/iep_regs_props.sv ----
// assertion checker for the interrupt enable/priority register block
module iep_regs_props
  import iep_pkg::*;
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [15:0] src_flag_3,
  input wire logic [15:0] src_flag_6,
  input wire logic        ext_input0_pending,
  input wire logic [15:0] irq_req_3,
  input wire logic [15:0] irq_req_6,
  input wire logic        timer1_req,
  input wire logic        ext_input0_req,
  input wire logic [2:0]  timer1_irq_level,
  input wire logic [2:0]  compare1_irq_level,
  input wire logic [2:0]  capture1_irq_level,
  input wire logic [2:0]  ext_input0_irq_level
);
  wire logic [11:0] lvls;

  assign lvls = {timer1_irq_level, compare1_irq_level, capture1_irq_level, ext_input0_irq_level};

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  reset_levels_a: assert property ($rose(aresetn) |-> lvls == 12'h924)
    else $error("priority levels not at reset value");
  reset_reqs_a: assert property ($rose(aresetn) |-> (irq_req_3 == 16'h0 && irq_req_6 == 16'h0)[*2])
    else $error("request seen with enables fresh from reset");
  req_gate_a: assert property (aresetn |=> ((irq_req_3 & ~($past(src_flag_3) & ENABLE_3_MASK))
    | (irq_req_6 & ~($past(src_flag_6) & ENABLE_6_MASK))) == 16'h0)
    else $error("request without flag or on unimplemented bit");
  level_off_a: assert property (aresetn && timer1_irq_level == LEVEL_OFF |=> !timer1_req)
    else $error("request passed with level zero");
  level_req_a: assert property (aresetn && ext_input0_pending && ext_input0_irq_level != LEVEL_OFF
    |=> ext_input0_req)
    else $error("pending source with nonzero level not requested");
  level_change_a: assert property (aresetn && !$stable(lvls) |-> $rose(s_axi_bvalid))
    else $error("level changed without a write");
  rdata_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0)
    else $error("upper read data not zero");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before ready");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before ready");
  wr_answer_a: assert property (aresetn && s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |=> s_axi_bvalid)
    else $error("write response late");
  rd_answer_a: assert property (aresetn && s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");

  cover property (s_axi_bvalid && s_axi_bready);
  cover property (timer1_req);
  cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
endmodule

bind iep_regs iep_regs_props iep_regs_props_inst (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .src_flag_3,
  .src_flag_6, .ext_input0_pending, .irq_req_3, .irq_req_6, .timer1_req, .ext_input0_req,
  .timer1_irq_level, .compare1_irq_level, .capture1_irq_level, .ext_input0_irq_level);

// ---- testbench/irq_enable_priority_regs_tb.sv ----
// self-checking bench for the interrupt enable/priority registers
module irq_enable_priority_regs_tb
  import iep_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = '0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic [15:0] src_flag_3 = '0, src_flag_4 = '0, src_flag_5 = '0, src_flag_6 = '0;
  logic        timer1_pending = 1'b0, compare1_pending = 1'b0;
  logic        capture1_pending = 1'b0, ext_input0_pending = 1'b0;
  logic [15:0] irq_req_3, irq_req_4, irq_req_5, irq_req_6, v, e [4], f [4];
  logic        timer1_req, compare1_req, capture1_req, ext_input0_req;
  logic [2:0]  timer1_irq_level, compare1_irq_level, capture1_irq_level, ext_input0_irq_level;
  logic [3:0]  p;
  logic [31:0] d;
  logic [7:0]  ofs [5] = '{OFS_ENABLE_3, OFS_ENABLE_4, OFS_ENABLE_5, OFS_ENABLE_6, OFS_PRIORITY_0};
  logic [15:0] msk [5] = '{ENABLE_3_MASK, ENABLE_4_MASK, ENABLE_5_MASK, ENABLE_6_MASK,
                           PRIORITY_0_MASK};
  logic [15:0] rst [5] = '{ENABLE_RST, ENABLE_RST, ENABLE_RST, ENABLE_RST, PRIORITY_0_RST};
  int          mismatches = 0, n_checks = 0;

  iep_regs iep_regs_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .src_flag_3,
    .src_flag_4, .src_flag_5, .src_flag_6, .timer1_pending, .compare1_pending, .capture1_pending,
    .ext_input0_pending, .irq_req_3, .irq_req_4, .irq_req_5, .irq_req_6, .timer1_req,
    .compare1_req, .capture1_req, .ext_input0_req, .timer1_irq_level, .compare1_irq_level,
    .capture1_irq_level, .ext_input0_irq_level);

  always #4 aclk = ~aclk;

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // ready on the response side is random in the first cycle only and is always high once the response is valid
  task automatic wr(input logic [7:0] a, input logic [15:0] dat, input logic [3:0] s,
                    output logic [1:0] resp);
    int i;
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'h0000, dat};
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'($urandom_range(1, 0));
    for (i = 0; i < 40; i++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) break;
      s_axi_bready <= 1'b1;
    end
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (i == 40) begin
      mismatches++;
      conclude();
    end
    @(posedge aclk);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] dat, output logic [1:0] resp);
    int i;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'($urandom_range(1, 0));
    for (i = 0; i < 40; i++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) break;
      s_axi_rready <= 1'b1;
    end
    dat = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (i == 40) begin
      mismatches++;
      conclude();
    end
    @(posedge aclk);
  endtask

  // a second call at the end of the run proves reset also restores written registers
  task automatic reset_and_check();
    aresetn <= 1'b0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int k = 0; k < 5; k++) begin
      rd(ofs[k], d, r);
      chk(d, {16'h0000, rst[k]});
    end
    chk({timer1_irq_level, compare1_irq_level, capture1_irq_level, ext_input0_irq_level},
        12'h924);
  endtask

  function automatic logic [3:0] lreq(input logic [15:0] lv, input logic [3:0] pend);
    return pend & {|lv[14:12], |lv[10:8], |lv[6:4], |lv[2:0]};
  endfunction

  initial begin
    void'($urandom(78668));
    reset_and_check();
    for (int k = 0; k < 5; k++) begin
      for (int j = 0; j < 3; j++) begin
        v = (j == 0) ? 16'hffff : 16'($urandom);
        wr(ofs[k], v, 4'hf, r);
        chk(r, RESP_OKAY);
        rd(ofs[k], d, r);
        chk(d, {16'h0000, v & msk[k]});
      end
      wr(ofs[k], 16'h0000, 4'h1, r);
      rd(ofs[k], d, r);
      chk(d, {16'h0000, v & msk[k] & 16'hff00});
    end
    wr(8'h18, 16'hffff, 4'hf, r);
    chk(r, RESP_SLVERR);
    rd(8'h18, d, r);
    chk(d, 32'h0);
    chk(r, RESP_SLVERR);
    wr(OFS_PENDING, 16'hffff, 4'hf, r);
    chk(r, RESP_OKAY);
    for (int n = 0; n < 8; n++) begin
      for (int k = 0; k < 4; k++) begin
        e[k] = (n == 0) ? 16'hffff : (n == 1) ? 16'h0000 : 16'($urandom);
        f[k] = (n < 2) ? 16'hffff : 16'($urandom);
        wr(ofs[k], e[k], 4'hf, r);
      end
      src_flag_3 <= f[0]; // flags stand in for ext inputs already routed to a pin
      src_flag_4 <= f[1];
      src_flag_5 <= f[2];
      src_flag_6 <= f[3];
      repeat (2) @(posedge aclk);
      chk({irq_req_3, irq_req_4}, {f[0] & e[0] & msk[0], f[1] & e[1] & msk[1]});
      chk({irq_req_5, irq_req_6}, {f[2] & e[2] & msk[2], f[3] & e[3] & msk[3]});
    end
    for (int n = 0; n < 16; n++) begin
      v = (n < 8) ? {4{1'b0, 3'(n)}} : 16'($urandom);
      p = (n < 8) ? 4'hf : 4'($urandom);
      {timer1_pending, compare1_pending, capture1_pending, ext_input0_pending} <= p;
      wr(OFS_PRIORITY_0, v, 4'hf, r);
      repeat (2) @(posedge aclk);
      chk({timer1_irq_level, compare1_irq_level, capture1_irq_level, ext_input0_irq_level},
          {v[14:12], v[10:8], v[6:4], v[2:0]});
      chk({timer1_req, compare1_req, capture1_req, ext_input0_req}, lreq(v, p));
      // the pending view: bits 7..4 are any request of enable registers 6..3
      rd(OFS_PENDING, d, r);
      chk(d, {24'h0, |(f[3] & e[3] & msk[3]), |(f[2] & e[2] & msk[2]),
              |(f[1] & e[1] & msk[1]), |(f[0] & e[0] & msk[0]), lreq(v, p)});
    end
    reset_and_check();
    conclude();
  end
endmodule
